// ===== rtl/cfl_pkg.sv
// Constants and types for the configuration reset and serial boot loader
// Behaviour
// - Config reset low 200 ns resets device
// - Reset release restarts configuration like power-up
// - Done shown by releasing config_done pull-down
// - User pins enabled 49 config clocks later
// - Oscillator clocks master mode, serial clock slave
// - Oscillator starts default, bitstream may speed up
// - Flash clock from oscillator, 50% duty cycle
// - Hold reset until supplies valid plus timeout
// - Test-port command sequences also reset logic
// - Serial port pins become user pins after done
// - Select pin high master, low slave mode
// - Wake command, deselect, wait 10 us
// - Fast read at address zero, eight dummy clocks
// - Shift out falling edge, sample rising, MSB first
// - Deselect after last bit, optional power-down
`default_nettype none
package cfl_pkg;
  localparam int CLK_MHZ = 125;
  localparam int RST_MIN_NS = 200;
  localparam int RST_MIN_CYC = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_WAIT_US = 10;
  localparam int WAKE_WAIT_CYC = WAKE_WAIT_US * CLK_MHZ;
  localparam int POR_WAIT_US = 10;
  localparam int POR_WAIT_CYC = POR_WAIT_US * CLK_MHZ;
  localparam int USER_IO_DELAY = 49;
  localparam logic [7:0] CMD_WAKE = 8'hab;
  localparam logic [7:0] CMD_FAST_READ = 8'h0b;
  localparam logic [7:0] CMD_POWER_DOWN = 8'hb9;
  localparam logic [23:0] START_ADDR = 24'h000000;
  localparam int DUMMY_BITS = 8;
  localparam int CMD_READ_BITS = 32;

  typedef enum logic [9:0] {
    CFL_ST_SAMPLE = 10'h001,
    CFL_ST_WAKE = 10'h002,
    CFL_ST_GAP = 10'h004,
    CFL_ST_READ_CMD = 10'h008,
    CFL_ST_DUMMY = 10'h010,
    CFL_ST_DATA = 10'h020,
    CFL_ST_PD_GAP = 10'h040,
    CFL_ST_PD_CMD = 10'h080,
    CFL_ST_WAKEUP_IO = 10'h100,
    CFL_ST_SLAVE = 10'h200
  } cfl_state_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic sel_n_out;
    logic sel_n_oe;
  } cfl_flash_out_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } cfl_byte_t;
endpackage : cfl_pkg
`default_nettype wire

// ===== rtl/cfl_loader.sv
// Configuration sequencer: resets, mode select and serial flash reader
`default_nettype none
module cfl_loader #(
  parameter int IMAGE_BYTES = 4096,
  parameter int WAKE_CYC = cfl_pkg::WAKE_WAIT_CYC,
  parameter int POR_CYC = cfl_pkg::POR_WAIT_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_config_reset_n,
  input wire logic i_supplies_ok,
  input wire logic i_spi_supply_ok,
  input wire logic i_test_port_reset,
  input wire logic i_select_pin,
  input wire logic i_flash_miso,
  input wire logic i_fast_osc_req,
  input wire logic i_power_down_en,
  output cfl_pkg::cfl_flash_out_t o_flash,
  output cfl_pkg::cfl_byte_t o_byte,
  output logic o_config_done_oe,
  output logic o_user_io_en,
  output logic o_master_mode,
  output logic o_fast_osc,
  output logic o_load_error
);
  import cfl_pkg::*;

  localparam int IMG_BITS = IMAGE_BYTES * 8;
  localparam int BITW = $clog2(IMG_BITS + 1);
  localparam int WW = $clog2(WAKE_CYC + POR_CYC + 2);

  // Counters below are sized from these values
  if (IMAGE_BYTES < 1) begin : g_bad_image
    $error("cfl_loader: IMAGE_BYTES must be at least 1");
  end
  if (WAKE_CYC < 1) begin : g_bad_wake
    $error("cfl_loader: WAKE_CYC must be at least 1");
  end
  if (POR_CYC < 1) begin : g_bad_por
    $error("cfl_loader: POR_CYC must be at least 1");
  end
  if (RST_MIN_CYC > 255) begin : g_bad_rst
    $error("cfl_loader: reset filter count exceeds its counter");
  end
  if (USER_IO_DELAY > 63) begin : g_bad_io
    $error("cfl_loader: user pin delay exceeds its counter");
  end

  // Two-flop synchronisers for pin inputs
  logic [1:0] rst_s_q;
  logic [1:0] sel_s_q;
  logic [1:0] miso_s_q;
  logic [1:0] sup_s_q;
  logic [1:0] spi_s_q;
  logic [1:0] tp_s_q;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s_q <= 2'h3;
      sel_s_q <= 2'h3;
      miso_s_q <= 2'h3;
      sup_s_q <= 2'h0;
      spi_s_q <= 2'h0;
      tp_s_q <= 2'h0;
    end else begin
      rst_s_q <= {rst_s_q[0], i_config_reset_n};
      sel_s_q <= {sel_s_q[0], i_select_pin};
      miso_s_q <= {miso_s_q[0], i_flash_miso};
      sup_s_q <= {sup_s_q[0], i_supplies_ok};
      spi_s_q <= {spi_s_q[0], i_spi_supply_ok};
      tp_s_q <= {tp_s_q[0], i_test_port_reset};
    end
  end

  wire cfg_rst_low = !rst_s_q[1];
  wire sel_high = sel_s_q[1];
  wire miso = miso_s_q[1];

  // Count low time of config reset; shorter glitches are ignored
  logic [7:0] low_cnt_q;
  wire pin_reset = (low_cnt_q >= 8'(RST_MIN_CYC));
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_cnt_q <= 8'h00;
    end else if (!cfg_rst_low) begin
      low_cnt_q <= 8'h00;
    end else if (!pin_reset) begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end

  // Held in reset until pin released after a valid low pulse
  logic pin_hold_q;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_hold_q <= 1'b0;
    end else if (pin_reset) begin
      pin_hold_q <= 1'b1;
    end else if (!cfg_rst_low) begin
      pin_hold_q <= 1'b0;
    end
  end

  // Power-on: supplies, then extra delay once flash supply is up
  logic [WW-1:0] por_cnt_q;
  wire por_busy = !sup_s_q[1] || !spi_s_q[1];
  wire por_done = (por_cnt_q == WW'(POR_CYC));
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      por_cnt_q <= '0;
    end else if (por_busy) begin
      por_cnt_q <= '0;
    end else if (!por_done) begin
      por_cnt_q <= por_cnt_q + WW'(1);
    end
  end

  wire any_reset = !por_done || pin_hold_q || pin_reset || tp_s_q[1];

  cfl_state_t st_q, st_d;
  logic [WW-1:0] wait_q;
  logic [BITW-1:0] bit_q;
  logic [5:0] sh_cnt_q;
  logic [31:0] sh_q;
  logic sck_q;
  logic ssn_q;
  logic done_q;
  logic master_q;
  logic fast_q;
  logic [7:0] rx_q;
  cfl_byte_t byte_q;
  logic [5:0] io_cnt_q;

  wire sck_rise = !sck_q;
  wire sck_fall = sck_q;
  wire wait_done = (wait_q == WW'(WAKE_CYC));
  wire sh_last = (sh_cnt_q == 6'h00);
  wire img_last = (bit_q == BITW'(IMG_BITS - 1));

  always_comb begin
    st_d = st_q;
    case (st_q)
      CFL_ST_SAMPLE: st_d = sel_high ? CFL_ST_WAKE : CFL_ST_SLAVE;
      CFL_ST_WAKE: if (sck_fall && sh_last) st_d = CFL_ST_GAP;
      CFL_ST_GAP: if (wait_done) st_d = CFL_ST_READ_CMD;
      CFL_ST_READ_CMD: if (sck_fall && sh_last) st_d = CFL_ST_DUMMY;
      CFL_ST_DUMMY: if (sck_fall && sh_last) st_d = CFL_ST_DATA;
      CFL_ST_DATA: if (sck_fall && img_last) begin
        st_d = i_power_down_en ? CFL_ST_PD_GAP : CFL_ST_WAKEUP_IO;
      end
      CFL_ST_PD_GAP: st_d = CFL_ST_PD_CMD;
      CFL_ST_PD_CMD: if (sck_fall && sh_last) st_d = CFL_ST_WAKEUP_IO;
      CFL_ST_WAKEUP_IO: st_d = CFL_ST_WAKEUP_IO;
      CFL_ST_SLAVE: st_d = CFL_ST_SLAVE;
      default: st_d = CFL_ST_SAMPLE;
    endcase
  end

  wire shifting = (st_q == CFL_ST_WAKE) || (st_q == CFL_ST_READ_CMD) ||
    (st_q == CFL_ST_DUMMY) || (st_q == CFL_ST_DATA) ||
    (st_q == CFL_ST_PD_CMD);
  wire enter = (st_d != st_q);

  // Sequencer; reset sources all land in mode sampling
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= CFL_ST_SAMPLE;
    end else if (any_reset) begin
      st_q <= CFL_ST_SAMPLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Serial clock toggles each core cycle while shifting: exact 50% duty
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sck_q <= 1'b0;
    end else if (any_reset || !shifting || (sck_fall && enter)) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= !sck_q;
    end
  end

  // Shift register and bit counters
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_q <= 32'h0;
      sh_cnt_q <= 6'h00;
      wait_q <= '0;
      bit_q <= '0;
      ssn_q <= 1'b1;
    end else if (any_reset) begin
      ssn_q <= 1'b1;
      wait_q <= '0;
      bit_q <= '0;
    end else if (st_q == CFL_ST_SAMPLE && sel_high) begin
      sh_q <= {CMD_WAKE, 24'h0};
      sh_cnt_q <= 6'd7;
      ssn_q <= 1'b0;
    end else if (st_q == CFL_ST_GAP) begin
      wait_q <= wait_q + WW'(1);
      if (wait_done) begin
        sh_q <= {CMD_FAST_READ, START_ADDR};
        sh_cnt_q <= 6'(CMD_READ_BITS - 1);
        ssn_q <= 1'b0;
      end
    end else if (st_q == CFL_ST_PD_GAP) begin
      sh_q <= {CMD_POWER_DOWN, 24'h0};
      sh_cnt_q <= 6'd7;
      ssn_q <= 1'b0;
    end else if (shifting && sck_fall) begin
      sh_q <= {sh_q[30:0], 1'b0};
      sh_cnt_q <= sh_cnt_q - 6'h01;
      if (st_q == CFL_ST_DATA) begin
        bit_q <= bit_q + BITW'(1);
      end
      if (enter) begin
        if (st_q == CFL_ST_READ_CMD) begin
          sh_cnt_q <= 6'(DUMMY_BITS - 1);
        end
        if (st_q != CFL_ST_READ_CMD && st_q != CFL_ST_DUMMY) begin
          ssn_q <= 1'b1;
        end
      end
    end
  end

  // Synchronised data lags the pin by one serial clock period, so each
  // bit is taken two core cycles after the rising edge it belongs to
  logic [1:0] rise_q;
  wire in_data = (st_q == CFL_ST_DATA);
  wire rx_take = !any_reset && rise_q[1];
  wire rx_byte_end = (bit_q[2:0] == 3'h0);
  wire [7:0] rx_next = {rx_q[6:0], miso};
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rise_q <= 2'h0;
    end else begin
      rise_q <= {rise_q[0], !any_reset && in_data && sck_rise};
    end
  end

  // Receive bytes MSB first
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_q <= 8'h00;
      byte_q <= '0;
    end else begin
      byte_q.valid <= 1'b0;
      if (rx_take) begin
        rx_q <= rx_next;
        if (rx_byte_end) begin
          byte_q.valid <= 1'b1;
          byte_q.data <= rx_next;
        end
      end
    end
  end

  // Done, user-pin delay, mode and oscillator speed
  wire loaded = (st_q == CFL_ST_WAKEUP_IO);
  wire io_ready = (io_cnt_q == 6'(USER_IO_DELAY));
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_q <= 1'b0;
      io_cnt_q <= 6'h00;
      master_q <= 1'b0;
      fast_q <= 1'b0;
    end else if (any_reset) begin
      done_q <= 1'b0;
      io_cnt_q <= 6'h00;
      fast_q <= 1'b0;
    end else begin
      if (st_q == CFL_ST_SAMPLE) begin
        master_q <= sel_high;
      end
      if (st_q == CFL_ST_DATA && i_fast_osc_req) begin
        fast_q <= 1'b1;
      end
      if (loaded) begin
        done_q <= 1'b1;
      end
      // Delay counts from the cycle done first shows on the pin
      if (loaded && done_q && !io_ready) begin
        io_cnt_q <= io_cnt_q + 6'h01;
      end
    end
  end

  assign o_config_done_oe = !done_q;
  assign o_user_io_en = io_ready;
  assign o_master_mode = master_q;
  assign o_fast_osc = fast_q;
  assign o_load_error = 1'b0;
  assign o_byte = byte_q;
  assign o_flash.sck = sck_q;
  assign o_flash.mosi = sh_q[31];
  assign o_flash.sel_n_out = ssn_q;
  assign o_flash.sel_n_oe = master_q && !o_user_io_en;
endmodule : cfl_loader
`default_nettype wire

// ===== verification/cfl_asserts.sv
// Port checker for the configuration loader
`default_nettype none
module cfl_asserts (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_config_reset_n,
  input wire logic i_supplies_ok,
  input wire logic i_test_port_reset,
  input wire cfl_pkg::cfl_flash_out_t o_flash,
  input wire cfl_pkg::cfl_byte_t o_byte,
  input wire logic o_config_done_oe,
  input wire logic o_user_io_en,
  input wire logic o_master_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  import cfl_pkg::*;
  logic [7:0] done_cnt_q;
  logic [7:0] low_cnt_q;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_cnt_q <= 8'h00;
      low_cnt_q <= 8'h00;
    end else begin
      done_cnt_q <= o_config_done_oe ? 8'h00 : done_cnt_q + 8'h01;
      low_cnt_q <= i_config_reset_n ? 8'h00 : low_cnt_q + 8'h01;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  sequence sck_pulse;
    o_flash.sck ##1 !o_flash.sck;
  endsequence
  sequence flash_quiet;
    o_config_done_oe && o_flash.sel_n_out;
  endsequence
  io_delay_a: assert property (
    $rose(o_user_io_en) |-> done_cnt_q == 8'd49)
    else $error("user pins enabled at wrong delay");
  slave_quiet_a: assert property (
    !o_master_mode |-> o_flash.sel_n_out && !o_flash.sck)
    else $error("flash touched in slave mode");
  sck_duty_a: assert property ($rose(o_flash.sck) |-> sck_pulse)
    else $error("serial clock high too long");
  mosi_edge_a: assert property (
    !o_flash.sel_n_out && $changed(o_flash.mosi) |-> !o_flash.sck)
    else $error("data out moved off falling clock");
  done_desel_a: assert property (
    $fell(o_config_done_oe) |-> o_flash.sel_n_out [*1] ##0
    $past(o_flash.sel_n_out))
    else $error("done while flash selected");
  pin_reset_a: assert property (
    low_cnt_q > 8'd34 |-> o_config_done_oe && !o_user_io_en)
    else $error("config reset pin ignored");
  supply_reset_a: assert property (!i_supplies_ok [*8] |-> flash_quiet)
    else $error("running with supplies down");
  test_reset_a: assert property (
    i_test_port_reset |-> ##[1:4] flash_quiet)
    else $error("test port reset ignored");
endmodule : cfl_asserts
bind cfl_loader cfl_asserts cfl_asserts_i (.i_core_clk, .i_rst_n,
  .i_config_reset_n, .i_supplies_ok, .i_test_port_reset, .o_flash,
  .o_byte, .o_config_done_oe, .o_user_io_en, .o_master_mode);
`default_nettype wire

// ===== verification/cfl_flash_model.sv
// Behavioural serial flash answering fast read with bytes counting up from 8'hc3
`default_nettype none
module cfl_flash_model (
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_sel_n,
  output logic o_miso,
  output logic [23:0] o_cmds,
  output logic [23:0] o_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] sh;
  logic [7:0] v;
  int bits;
  initial begin
    o_miso = 1'b1;
    o_cmds = 24'h000000;
    o_addr = 24'hffffff;
    bits = 0;
  end
  always @(negedge i_sel_n) bits = 0;
  // Released output floats to the pull-up level
  always @(posedge i_sel_n) o_miso = 1'b1;
  always @(posedge i_sck) begin
    if (!i_sel_n) begin
      sh = {sh[30:0], i_mosi};
      bits++;
      if (bits == 8) o_cmds = {o_cmds[15:0], sh[7:0]};
      if (bits == 32) o_addr = sh[23:0];
    end
  end
  // Eight dummy clocks pass before the first data bit
  always @(negedge i_sck) begin
    if (!i_sel_n && o_cmds[7:0] == 8'h0b && bits >= 40) begin
      v = 8'hc3 + 8'((bits - 40) / 8);
      o_miso = v[7 - (bits - 40) % 8];
    end
  end
endmodule : cfl_flash_model
`default_nettype wire

// ===== verification/test_cfl_loader.sv
// Self-checking bench for the configuration loader
`default_nettype none
`define CHK(nm, ex, sn) \
  n_tests++; \
  if ((sn) !== (ex)) begin \
    $display("BAD %s exp %h got %h", nm, ex, sn); \
    error_cnt++; \
  end
module test_cfl_loader;
  timeunit 1ns;
  timeprecision 1ps;
  import cfl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_n = 1'b1;
  logic sup = 1'b1;
  logic tst = 1'b0;
  logic sel_pin = 1'b1;
  logic pd = 1'b0;
  logic fast = 1'b0;
  logic miso;
  cfl_flash_out_t fl;
  cfl_byte_t by;
  logic done_oe, io_en, master, fosc;
  logic [23:0] cmds, addr;
  logic [7:0] got[$];
  int error_cnt = 0;
  int n_tests = 0;
  always #4 clk = ~clk;
  always @(negedge clk) if (by.valid === 1'b1) got.push_back(by.data);
  cfl_loader #(.IMAGE_BYTES(2), .WAKE_CYC(4), .POR_CYC(4)) cfl_loader_i (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_config_reset_n(cfg_n),
    .i_supplies_ok(sup), .i_spi_supply_ok(sup), .i_test_port_reset(tst),
    .i_select_pin(sel_pin), .i_flash_miso(miso), .i_fast_osc_req(fast),
    .i_power_down_en(pd), .o_flash(fl), .o_byte(by),
    .o_config_done_oe(done_oe), .o_user_io_en(io_en),
    .o_master_mode(master), .o_fast_osc(fosc), .o_load_error());
  cfl_flash_model cfl_flash_model_i (.i_sck(fl.sck), .i_mosi(fl.mosi),
    .i_sel_n(fl.sel_n_out), .o_miso(miso), .o_cmds(cmds), .o_addr(addr));
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic wait_done;
    for (int i = 0; i < 3000 && done_oe !== 1'b0; i++) @(negedge clk);
    if (done_oe !== 1'b0) begin
      $display("BAD done wait exp 0 got %b", done_oe);
      error_cnt++;
      complete_run();
    end
  endtask : wait_done
  // Pulse config reset low for n cycles; got is cleared once it is released
  task automatic cfg_pulse(input int n);
    cfg_n = 1'b0;
    repeat (n) @(negedge clk);
    cfg_n = 1'b1;
    got.delete();
  endtask : cfg_pulse
  task automatic check_image;
    `CHK("byte count", 2, got.size())
    `CHK("byte 0", 8'hc3, got[0])
    `CHK("byte 1", 8'hc4, got[1])
  endtask : check_image
  task automatic t_boot(input logic p, input logic f);
    pd = p;
    fast = f;
    cfg_pulse(40);
    wait_done();
    `CHK("cmd log", p ? 24'hab0bb9 : 24'hb9ab0b, cmds)
    `CHK("start addr", START_ADDR, addr)
    `CHK("master", 1'b1, master)
    `CHK("fast osc", f, fosc)
    repeat (60) @(negedge clk);
    check_image();
    `CHK("user pins", 1'b1, io_en)
    `CHK("select oe", 1'b0, fl.sel_n_oe)
  endtask : t_boot
  task automatic t_short;
    cfg_pulse(10);
    repeat (40) @(negedge clk);
    `CHK("short pulse", 1'b0, done_oe)
  endtask : t_short
  task automatic t_abort(input logic s);
    cfg_pulse(40);
    repeat (70) @(negedge clk);
    `CHK("select driven", 1'b1, fl.sel_n_oe)
    if (s) sup = 1'b0;
    else tst = 1'b1;
    repeat (12) @(negedge clk);
    `CHK("done held", 1'b1, done_oe)
    `CHK("flash released", 1'b1, fl.sel_n_out)
    sup = 1'b1;
    tst = 1'b0;
    got.delete();
    wait_done();
    repeat (2) @(negedge clk);
    check_image();
  endtask : t_abort
  task automatic t_slave;
    sel_pin = 1'b0;
    cfg_pulse(40);
    repeat (300) @(negedge clk);
    `CHK("slave", 1'b0, master)
    `CHK("not done", 1'b1, done_oe)
    `CHK("flash idle", 1'b1, fl.sel_n_out)
  endtask : t_slave
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    wait_done();
    `CHK("por cmd log", 24'h00ab0b, cmds)
    repeat (2) @(negedge clk);
    check_image();
    t_boot(1'b1, 1'b0);
    t_boot(1'b0, 1'b1);
    t_short();
    t_abort(1'b0);
    t_abort(1'b1);
    t_slave();
    complete_run();
  end
endmodule : test_cfl_loader
`default_nettype wire
